//--- hw/mio_terminal.sv
/*
  Multi-function digital terminal logic: output polarity, pulse counter,
  frequency and speed indications, pulse-frequency output, restart with
  held run command and terminal status bitmaps.
  Assumes all inputs synchronous to i_clk and a one-cycle register port.
*/
// Chosen here: the plain strobed port and the register offsets.
// Overview of operation
// (RULE1) 16-bit output polarity mask, reset zero; a one inverts that output. Outputs claimed by the sequence controller take its level uninverted.
// (RULE2) mask bit 0 relay, bit 3 transistor a, bit 4 transistor b.
// (RULE3) counter triggers come from digital input six when its code is 23.
// (RULE4) reaching terminal count activates function 18 outputs and clears count.
// (RULE5) reaching preliminary count activates function 17 outputs, no clear.
// (RULE6) counter steps on rising trigger edges and saturates at 16-bit max.
// (RULE7) pulse output is 50 % square at output frequency times gain 1..55.
// (RULE8) functions 3 and 4 close when output frequency is within width of target.
// (RULE9) function 29 active at or above threshold, function 30 below it.
// (RULE10) restart option 1 starts after power-up or reset key if run is held.
// (RULE11) function 43 on while measured speed is below zero-speed level.
// (RULE12) input status bitmap, bits 0..6 for inputs one..seven, one is active.
// (RULE13) output status bitmap, relay bit 0, transistor a bit 3, one is on.
// (RULE14) bitmap of inputs claimed by the sequence controller, input positions.
// (RULE15) bitmap of outputs claimed by the sequence controller, output positions.
`timescale 1ns/1ps
`default_nettype none

module mio_terminal #(
  parameter longint unsigned CLK_HZ      = mio_pkg::CLK_HZ_DEF,
  parameter logic            RESTART_RST = 1'b0
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // register port
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output var  logic [15:0] o_rdata,
  // terminals
  input  wire logic [6:0]  i_digital_input,
  output wire logic        o_relay_output,
  output wire logic        o_transistor_output_a,
  output wire logic        o_transistor_output_b,
  output var  logic        o_pulse_frequency_output,
  // drive values
  input  wire logic [15:0] i_out_freq,
  input  wire logic [15:0] i_cmd_freq,
  input  wire logic [15:0] i_motor_speed,
  input  wire logic        i_run_held,
  input  wire logic        i_reset_key,
  output var  logic        o_run_start,
  // sequence controller
  input  wire logic [6:0]  i_seq_in_claim,
  input  wire logic [2:0]  i_seq_out_claim,
  input  wire logic [2:0]  i_seq_out_level,
  // interrupt
  output var  logic        o_irq
);

  localparam logic [35:0] ACC_LIM = 36'(CLK_HZ * mio_pkg::FREQ_SCALE);

  // ************************************************************
  // registers
  // ************************************************************
  logic [15:0] pol_r;
  logic [7:0]  fn_r [3];
  logic [7:0]  trig_fn_r;
  logic [15:0] term_r;
  logic [15:0] pre_r;
  logic [7:0]  gain_r;
  logic [15:0] width_r;
  logic [15:0] thr_r;
  logic [15:0] zspd_r;
  logic        restart_r;
  logic [2:0]  irq_sts_r;
  logic [2:0]  irq_msk_r;
  logic [6:0]  din_r;
  logic [6:0]  din_q;
  logic [15:0] cnt_r;
  logic        term_act_r;
  logic        pre_act_r;
  logic [2:0]  out_r;
  logic [35:0] acc_r;
  logic        pend_r;
  logic [15:0] rd_val;
  logic [15:0] out_map;
  logic [15:0] oclm_map;
  logic [2:0]  irq_evt;
  logic [2:0]  irq_nxt;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pol_r     <= mio_pkg::POL_RST;
      trig_fn_r <= 8'h00;
      term_r    <= 16'h0000;
      pre_r     <= 16'h0000;
      gain_r    <= mio_pkg::GAIN_MIN;
      width_r   <= mio_pkg::WIDTH_RST;
      thr_r     <= 16'h0000;
      zspd_r    <= 16'h0000;
      restart_r <= RESTART_RST;
      irq_msk_r <= 3'h0;
    end
    else if (i_wr)
    begin
      case (i_addr)
        mio_pkg::ADDR_POL:     pol_r     <= i_wdata; // see (RULE1)
        mio_pkg::ADDR_TRIGFN:  trig_fn_r <= i_wdata[7:0];
        mio_pkg::ADDR_TERM:    term_r    <= (i_wdata > mio_pkg::TERM_MAX) ?
                                            mio_pkg::TERM_MAX : i_wdata;
        mio_pkg::ADDR_PRE:     pre_r     <= (i_wdata > mio_pkg::TERM_MAX) ?
                                            mio_pkg::TERM_MAX : i_wdata;
        mio_pkg::ADDR_GAIN:    gain_r    <= (i_wdata[15:8] != 8'h00 ||
                                             i_wdata[7:0] > mio_pkg::GAIN_MAX) ?
                                            mio_pkg::GAIN_MAX :
                                            (i_wdata[7:0] < mio_pkg::GAIN_MIN) ?
                                            mio_pkg::GAIN_MIN : i_wdata[7:0];
        mio_pkg::ADDR_WIDTH:   width_r   <= i_wdata;
        mio_pkg::ADDR_THR:     thr_r     <= i_wdata;
        mio_pkg::ADDR_ZSPD:    zspd_r    <= i_wdata;
        mio_pkg::ADDR_RESTART: restart_r <= i_wdata[0];
        mio_pkg::ADDR_IRQMSK:  irq_msk_r <= i_wdata[2:0];
        default:               ;
      endcase
    end
  end

  // ************************************************************
  // interrupt status, set wins over write-one clear
  // ************************************************************
  assign irq_nxt = (irq_sts_r & ~((i_wr && i_addr == mio_pkg::ADDR_IRQSTS) ?
                   i_wdata[2:0] : 3'h0)) | irq_evt;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      irq_sts_r <= 3'h0;
      o_irq     <= 1'b0;
    end
    else
    begin
      irq_sts_r <= irq_nxt;
      o_irq     <= |(irq_nxt & irq_msk_r);
    end
  end

  // ************************************************************
  // input sampling and pulse counter
  // ************************************************************
  logic        trig_edge;
  logic [15:0] cnt_inc;
  logic        term_hit;
  logic        pre_hit;

  assign trig_edge = (trig_fn_r == mio_pkg::FN_CNT_TRIG) &&
                     din_r[mio_pkg::TRIG_BIT] && !din_q[mio_pkg::TRIG_BIT]; // see (RULE3)
  assign cnt_inc   = (cnt_r == mio_pkg::CNT_MAX) ? cnt_r : cnt_r + 16'h0001; // see (RULE6)
  assign term_hit  = trig_edge && term_r != 16'h0000 && cnt_inc >= term_r;
  assign pre_hit   = trig_edge && !term_hit && pre_r != 16'h0000 && cnt_inc == pre_r;
  assign irq_evt   = {o_run_start, pre_hit, term_hit};
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      din_r <= 7'h00;
      din_q <= 7'h00;
    end
    else
    begin
      din_r <= i_digital_input;
      din_q <= din_r;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r      <= 16'h0000;
      term_act_r <= 1'b0;
      pre_act_r  <= 1'b0;
    end
    else if (trig_edge)
    begin
      cnt_r      <= term_hit ? 16'h0000 : cnt_inc; // see (RULE4) (RULE6)
      term_act_r <= term_hit;
      pre_act_r  <= pre_hit || (pre_act_r && !term_hit); // see (RULE5)
    end
  end

  trig_qual_a: assert property ( // see (RULE3)
    trig_fn_r != mio_pkg::FN_CNT_TRIG |=> $stable(cnt_r))
    else $error("counter moved without qualified trigger");
  term_wrap_a: assert property ( // see (RULE4)
    term_hit |=> cnt_r == 16'h0000 && term_act_r)
    else $error("terminal count did not clear counter");
  pre_hold_a: assert property ( // see (RULE5)
    pre_hit |=> pre_act_r && cnt_r == $past(cnt_inc) && cnt_r != 16'h0000)
    else $error("preliminary count reset counter or not flagged");
  cnt_sat_a: assert property ( // see (RULE6)
    term_r == 16'h0000 && cnt_r == mio_pkg::CNT_MAX |=> cnt_r == mio_pkg::CNT_MAX)
    else $error("counter wrapped at maximum");
  cnt_step_a: assert property ( // see (RULE6)
    trig_edge && !term_hit && cnt_r < mio_pkg::CNT_MAX |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not step by one");

  // ************************************************************
  // output functions, polarity and sequencer override
  // ************************************************************
  logic [15:0] fdiff;
  logic        attain_c;
  logic        ge_c;
  logic        zs_c;

  assign fdiff    = (i_out_freq >= i_cmd_freq) ? i_out_freq - i_cmd_freq :
                                                  i_cmd_freq - i_out_freq;
  assign attain_c = fdiff <= width_r; // see (RULE8)
  assign ge_c     = i_out_freq >= thr_r; // see (RULE9)
  assign zs_c     = i_motor_speed < zspd_r; // see (RULE11)

  genvar g;
  generate
    for (g = 0; g < mio_pkg::NUM_OUT; g++)
    begin : g_out
      logic cond;
      always_comb
      begin
        case (fn_r[g])
          mio_pkg::FN_ATTAIN1,
          mio_pkg::FN_ATTAIN2:  cond = attain_c;
          mio_pkg::FN_PRELIM:   cond = pre_act_r;
          mio_pkg::FN_TERM:     cond = term_act_r;
          mio_pkg::FN_FREQ_GE:  cond = ge_c;
          mio_pkg::FN_FREQ_LT:  cond = !ge_c;
          mio_pkg::FN_ZERO_SPD: cond = zs_c;
          default:              cond = 1'b0;
        endcase
      end
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          fn_r[g] <= 8'h00;
        else if (i_wr && i_addr == mio_pkg::ADDR_FN0 + 5'(g))
          fn_r[g] <= i_wdata[7:0];
      end
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          out_r[g] <= 1'b0;
        else if (i_seq_out_claim[g])
          out_r[g] <= i_seq_out_level[g];
        else
          out_r[g] <= cond ^ pol_r[mio_pkg::OUT_POS[g]]; // see (RULE1) (RULE2)
      end

      assign out_map[mio_pkg::OUT_POS[g]]  = out_r[g]; // see (RULE13)
      assign oclm_map[mio_pkg::OUT_POS[g]] = i_seq_out_claim[g]; // see (RULE15)
    end
  endgenerate

  assign out_map[2:1]   = 2'h0;
  assign out_map[15:5]  = 11'h000;
  assign oclm_map[2:1]  = 2'h0;
  assign oclm_map[15:5] = 11'h000;

  assign o_relay_output        = out_r[0];
  assign o_transistor_output_a = out_r[1];
  assign o_transistor_output_b = out_r[2];

  pol_invert_a: assert property ( // see (RULE1) (RULE9)
    fn_r[0] == mio_pkg::FN_FREQ_GE && !i_seq_out_claim[0]
    |=> o_relay_output == ($past(ge_c) ^ $past(pol_r[0])))
    else $error("relay level does not follow threshold and polarity");
  attain_a: assert property ( // see (RULE8) (RULE2)
    fn_r[1] == mio_pkg::FN_ATTAIN1 && !i_seq_out_claim[1] && !pol_r[3] && fdiff <= width_r
    |=> o_transistor_output_a)
    else $error("attain output not closed within width");
  zero_spd_a: assert property ( // see (RULE11) (RULE2)
    fn_r[2] == mio_pkg::FN_ZERO_SPD && !i_seq_out_claim[2]
    |=> o_transistor_output_b == ($past(zs_c) ^ $past(pol_r[4])))
    else $error("zero speed output wrong");

  // ************************************************************
  // pulse-frequency output
  // ************************************************************
  logic [35:0] dfm_inc;
  logic [35:0] dfm_sum;
  logic        dfm_wrap;

  // two edges per pulse, so the step is doubled for 50 % duty
  assign dfm_inc  = 36'(i_out_freq) * 36'(gain_r) * 36'h000000002; // see (RULE7)
  assign dfm_sum  = acc_r + dfm_inc;
  assign dfm_wrap = dfm_sum >= ACC_LIM;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      acc_r                    <= 36'h000000000;
      o_pulse_frequency_output <= 1'b0;
    end
    else
    begin
      acc_r <= dfm_wrap ? dfm_sum - ACC_LIM : dfm_sum;
      if (dfm_wrap)
        o_pulse_frequency_output <= !o_pulse_frequency_output; // see (RULE7)
    end
  end

  dfm_toggle_a: assert property ( // see (RULE7)
    dfm_wrap |=> o_pulse_frequency_output != $past(o_pulse_frequency_output))
    else $error("pulse output missed a toggle");
  dfm_still_a: assert property ( // see (RULE7)
    i_out_freq == 16'h0000 |=> $stable(o_pulse_frequency_output))
    else $error("pulse output toggled at zero frequency");

  // ************************************************************
  // restart with held run command
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pend_r      <= 1'b1;
      o_run_start <= 1'b0;
    end
    else
    begin
      o_run_start <= pend_r && restart_r && i_run_held; // see (RULE10)
      pend_r      <= i_reset_key; // one-cycle window: started, option off or run released
    end
  end

  restart_a: assert property ( // see (RULE10)
    pend_r && restart_r && i_run_held
    |=> o_run_start ##1 (!o_run_start || $past(i_reset_key, 2)))
    else $error("restart not issued as one pulse");

  // ************************************************************
  // read port
  // ************************************************************
  always_comb
  begin
    case (i_addr)
      mio_pkg::ADDR_POL:     rd_val = pol_r;
      mio_pkg::ADDR_INST:    rd_val = {9'h000, din_r}; // see (RULE12)
      mio_pkg::ADDR_OUTST:   rd_val = out_map; // see (RULE13)
      mio_pkg::ADDR_INCLM:   rd_val = {9'h000, i_seq_in_claim}; // see (RULE14)
      mio_pkg::ADDR_OUTCLM:  rd_val = oclm_map; // see (RULE15)
      mio_pkg::ADDR_FN0:     rd_val = {8'h00, fn_r[0]};
      5'h06:                 rd_val = {8'h00, fn_r[1]};
      5'h07:                 rd_val = {8'h00, fn_r[2]};
      mio_pkg::ADDR_TRIGFN:  rd_val = {8'h00, trig_fn_r};
      mio_pkg::ADDR_TERM:    rd_val = term_r;
      mio_pkg::ADDR_PRE:     rd_val = pre_r;
      mio_pkg::ADDR_GAIN:    rd_val = {8'h00, gain_r};
      mio_pkg::ADDR_WIDTH:   rd_val = width_r;
      mio_pkg::ADDR_THR:     rd_val = thr_r;
      mio_pkg::ADDR_ZSPD:    rd_val = zspd_r;
      mio_pkg::ADDR_RESTART: rd_val = {15'h0000, restart_r};
      mio_pkg::ADDR_CNT:     rd_val = cnt_r;
      mio_pkg::ADDR_IRQSTS:  rd_val = {13'h0000, irq_sts_r};
      mio_pkg::ADDR_IRQMSK:  rd_val = {13'h0000, irq_msk_r};
      default:               rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rdata <= 16'h0000;
    else
      o_rdata <= i_rd ? rd_val : 16'h0000;
  end

  in_map_a: assert property ( // see (RULE12)
    i_rd && i_addr == mio_pkg::ADDR_INST |=> o_rdata == {9'h000, $past(din_r)})
    else $error("input bitmap readback wrong");
  out_map_a: assert property ( // see (RULE13) (RULE2)
    i_rd && i_addr == mio_pkg::ADDR_OUTST
    |=> o_rdata[0] == $past(o_relay_output) && o_rdata[3] == $past(o_transistor_output_a)
        && o_rdata[4] == $past(o_transistor_output_b) && o_rdata[2:1] == 2'h0)
    else $error("output bitmap readback wrong");
  claim_map_a: assert property ( // see (RULE15)
    i_rd && i_addr == mio_pkg::ADDR_OUTCLM
    |=> o_rdata[0] == $past(i_seq_out_claim[0]) && o_rdata[4] == $past(i_seq_out_claim[2]))
    else $error("claim bitmap readback wrong");
  term_cov: cover property (term_hit ##1 term_act_r);
  pre_cov: cover property (pre_hit ##[1:50] term_hit);
  dfm_cov: cover property (dfm_wrap ##[1:100] dfm_wrap);
  start_cov: cover property (i_reset_key ##2 o_run_start);

endmodule

`default_nettype wire

//--- hw/mio_pkg.sv
/*
  Constants shared by the multi-function terminal block: register map,
  field positions, reset values, terminal function codes and scaling.
  Assumes frequencies arrive in 0.01 Hz units and speeds in rpm.
*/
package mio_pkg;

  // ************************************************************
  // register indices (word addresses)
  // ************************************************************
  localparam logic [4:0] ADDR_POL     = 5'h00;
  localparam logic [4:0] ADDR_INST    = 5'h01;
  localparam logic [4:0] ADDR_OUTST   = 5'h02;
  localparam logic [4:0] ADDR_INCLM   = 5'h03;
  localparam logic [4:0] ADDR_OUTCLM  = 5'h04;
  localparam logic [4:0] ADDR_FN0     = 5'h05;
  localparam logic [4:0] ADDR_TRIGFN  = 5'h08;
  localparam logic [4:0] ADDR_TERM    = 5'h09;
  localparam logic [4:0] ADDR_PRE     = 5'h0a;
  localparam logic [4:0] ADDR_GAIN    = 5'h0b;
  localparam logic [4:0] ADDR_WIDTH   = 5'h0c;
  localparam logic [4:0] ADDR_THR     = 5'h0d;
  localparam logic [4:0] ADDR_ZSPD    = 5'h0e;
  localparam logic [4:0] ADDR_RESTART = 5'h0f;
  localparam logic [4:0] ADDR_CNT     = 5'h10;
  localparam logic [4:0] ADDR_IRQSTS  = 5'h11;
  localparam logic [4:0] ADDR_IRQMSK  = 5'h12;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int unsigned NUM_OUT      = 3;
  localparam int unsigned NUM_IN       = 7;
  localparam int unsigned OUT_POS [3]  = '{0, 3, 4};
  localparam int unsigned TRIG_BIT     = 5;
  localparam logic [15:0] POL_RST      = 16'h0000;
  localparam logic [15:0] WIDTH_RST    = 16'h00c8;
  localparam logic [15:0] TERM_MAX     = 16'hffdc;
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [7:0]  GAIN_MIN     = 8'h01;
  localparam logic [7:0]  GAIN_MAX     = 8'h37;
  localparam int unsigned IRQ_TERM     = 0;
  localparam int unsigned IRQ_PRE      = 1;
  localparam int unsigned IRQ_START    = 2;

  // ************************************************************
  // terminal function codes
  // ************************************************************
  localparam logic [7:0] FN_ATTAIN1  = 8'h03;
  localparam logic [7:0] FN_ATTAIN2  = 8'h04;
  localparam logic [7:0] FN_PRELIM   = 8'h11;
  localparam logic [7:0] FN_TERM     = 8'h12;
  localparam logic [7:0] FN_CNT_TRIG = 8'h17;
  localparam logic [7:0] FN_FREQ_GE  = 8'h1d;
  localparam logic [7:0] FN_FREQ_LT  = 8'h1e;
  localparam logic [7:0] FN_ZERO_SPD = 8'h2b;

  // ************************************************************
  // timing and scaling
  // ************************************************************
  localparam longint unsigned CLK_HZ_DEF = 64'd125000000;
  localparam longint unsigned FREQ_SCALE = 64'd100;

endpackage

//--- testbench/mio_field_model.sv
/*
  Field-side model: input contacts and the load on the pulse output.
  Assumes the bench moves the contacts and clears the load counters.
*/
`timescale 1ns/1ps
`default_nettype none

module mio_field_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // bench side
  input  wire logic [6:0]  i_contact,
  input  wire logic        i_clr,
  output var  logic [15:0] o_edge_cnt,
  output var  logic [15:0] o_high_cnt,
  // terminal side
  input  wire logic        i_pulse,
  output var  logic [6:0]  o_digital_input
);
  logic pulse_r;

  // ****
  // contacts settle one clock late; load counts edges and high time
  // ****
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_digital_input <= 7'h00;
      pulse_r         <= 1'b0;
      o_edge_cnt      <= 16'h0000;
      o_high_cnt      <= 16'h0000;
    end
    else
    begin
      o_digital_input <= i_contact;
      pulse_r         <= i_pulse;
      o_edge_cnt      <= i_clr ? 16'h0000 : o_edge_cnt + {15'h0000, i_pulse & ~pulse_r};
      o_high_cnt      <= i_clr ? 16'h0000 : o_high_cnt + {15'h0000, i_pulse};
    end
  end
endmodule

`default_nettype wire

//--- testbench/tb_mio_terminal.sv
/*
  Self-checking bench of the terminal block through its register port and pins.
  Assumes mio_pkg, mio_terminal and mio_field_model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_mio_terminal;
  localparam longint unsigned CLK_HZ_TB = 64'd100000;
  logic        clk, rst_b, wr, rd, run_held, reset_key, clr, rd_d, ok;
  logic        relay, tr_a, tr_b, pulse, run_start, irq;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, out_freq, cmd_freq, speed, edges, highs, rnd, f;
  logic [6:0]  contact, din, in_claim;
  logic [2:0]  out_claim, out_level;
  logic [15:0] exp_q[$];
  string       nm_q[$];
  int          n_errors, n_tests, run_cnt, n0;
  longint      ee;
  logic [15:0] pv [5] = '{16'h0006, 16'h0001, 16'h0008, 16'h0010, 16'h0019};
  logic [3:0]  ep [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7};
  logic [15:0] af [4] = '{16'h1450, 16'h1451, 16'h12c0, 16'h12bf};
  logic [2:0]  rs [3] = '{3'b111, 3'b100, 3'b010};

  mio_terminal #(.CLK_HZ(CLK_HZ_TB)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_digital_input(din), .o_relay_output(relay),
    .o_transistor_output_a(tr_a), .o_transistor_output_b(tr_b),
    .o_pulse_frequency_output(pulse), .i_out_freq(out_freq), .i_cmd_freq(cmd_freq),
    .i_motor_speed(speed), .i_run_held(run_held), .i_reset_key(reset_key),
    .o_run_start(run_start), .i_seq_in_claim(in_claim), .i_seq_out_claim(out_claim),
    .i_seq_out_level(out_level), .o_irq(irq));
  mio_field_model u_field (
    .i_clk(clk), .i_rst_b(rst_b), .i_contact(contact), .i_clr(clr), .o_edge_cnt(edges),
    .o_high_cnt(highs), .i_pulse(pulse), .o_digital_input(din));

  // ****
  // bus tasks, comparisons and read-data monitor
  // ****
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp16(string nm, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (e !== s)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_pins(string nm, logic [3:0] e);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      #1;
      if ({irq, tr_b, tr_a, relay} === e)
        break;
    end
    n_tests++;
    if ({irq, tr_b, tr_a, relay} !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, {irq, tr_b, tr_a, relay});
      summarize();
    end
  endtask
  task automatic wr_reg(logic [4:0] a, logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(logic [4:0] a, logic [15:0] e, string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
  endtask
  // one trigger pulse on input six
  task automatic trig();
    @(posedge clk);
    contact[5] <= 1'b1;
    repeat (4) @(posedge clk);
    contact[5] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    rd_d <= rd;
    if (run_start === 1'b1)
      run_cnt++;
    if (rd_d === 1'b1 && exp_q.size() > 0)
      cmp16(nm_q.pop_front(), exp_q.pop_front(), rdata);
  end

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****
  // stimulus
  // ****
  initial
  begin
    {wr, rd, run_held, reset_key, clr, rst_b} = '0;
    {addr, wdata, contact, out_freq, cmd_freq, speed, in_claim, out_claim, out_level} = '0;
    rnd = 16'h0012;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(mio_pkg::ADDR_POL, mio_pkg::POL_RST, "polarity");
    rd_reg(mio_pkg::ADDR_WIDTH, mio_pkg::WIDTH_RST, "width");
    wr_reg(5'h1f, 16'h5a5a);
    rd_reg(5'h1f, 16'h0000, "unmapped");
    wr_reg(mio_pkg::ADDR_INST, 16'hffff);
    rd_reg(mio_pkg::ADDR_INST, 16'h0000, "input state");
    wr_reg(mio_pkg::ADDR_GAIN, 16'h00ff);
    rd_reg(mio_pkg::ADDR_GAIN, {8'h00, mio_pkg::GAIN_MAX}, "gain");
    wr_reg(mio_pkg::ADDR_TERM, 16'hffff);
    rd_reg(mio_pkg::ADDR_TERM, mio_pkg::TERM_MAX, "terminal count");
    wr_reg(mio_pkg::ADDR_POL, 16'hffff);
    rd_reg(mio_pkg::ADDR_POL, 16'hffff, "polarity");
    for (int k = 0; k < 5; k++)
    begin
      wr_reg(mio_pkg::ADDR_POL, pv[k]);
      wait_pins("polarity", ep[k]);
    end
    rd_reg(mio_pkg::ADDR_OUTST, 16'h0019, "output state");
    $display("test registers and polarity done");
    wr_reg(mio_pkg::ADDR_POL, 16'h0000);
    wr_reg(mio_pkg::ADDR_FN0, {8'h00, mio_pkg::FN_FREQ_GE});
    wr_reg(mio_pkg::ADDR_FN0 + 5'h01, {8'h00, mio_pkg::FN_FREQ_LT});
    wr_reg(mio_pkg::ADDR_THR, 16'h03e8);
    for (int k = 0; k < 6; k++)
    begin
      rnd = lfsr(rnd);
      f = (k == 0) ? 16'h03e8 : (k == 1) ? 16'h03e7 : {5'h00, rnd[10:0]};
      out_freq <= f;
      wait_pins("threshold", {2'b00, f < 16'h03e8, f >= 16'h03e8});
    end
    wr_reg(mio_pkg::ADDR_FN0, 16'h0000);
    wr_reg(mio_pkg::ADDR_FN0 + 5'h01, 16'h0000);
    cmd_freq <= 16'h1388;
    for (int c = 0; c < 2; c++)
    begin
      wr_reg(mio_pkg::ADDR_FN0 + 5'h02, {8'h00, c ? mio_pkg::FN_ATTAIN2 : mio_pkg::FN_ATTAIN1});
      for (int j = 0; j < 4; j++)
      begin
        out_freq <= af[j];
        wait_pins("attain", {1'b0, j % 2 == 0, 2'b00});
      end
    end
    wr_reg(mio_pkg::ADDR_FN0 + 5'h02, 16'h0000);
    wr_reg(mio_pkg::ADDR_FN0, {8'h00, mio_pkg::FN_ZERO_SPD});
    wr_reg(mio_pkg::ADDR_ZSPD, 16'h0065);
    speed <= 16'h0064;
    wait_pins("zero speed", 4'b0001);
    speed <= 16'h0065;
    wait_pins("zero speed", 4'b0000);
    $display("test indications done");
    wr_reg(mio_pkg::ADDR_FN0, 16'h0000);
    {contact, in_claim, out_claim, out_level} <= {7'h34, 7'h34, 3'b001, 3'b001};
    wr_reg(mio_pkg::ADDR_POL, 16'h0001);
    wait_pins("claimed relay", 4'b0001);
    rd_reg(mio_pkg::ADDR_INST, 16'h0034, "input state");
    rd_reg(mio_pkg::ADDR_INCLM, 16'h0034, "inputs claimed");
    rd_reg(mio_pkg::ADDR_OUTCLM, 16'h0001, "outputs claimed");
    {out_claim, out_level} <= {3'b111, 3'b000};
    wr_reg(mio_pkg::ADDR_POL, 16'h0019);
    wait_pins("claimed all", 4'b0000);
    rd_reg(mio_pkg::ADDR_OUTCLM, 16'h0019, "outputs claimed");
    {contact, in_claim, out_claim} <= '0;
    wr_reg(mio_pkg::ADDR_POL, 16'h0000);
    $display("test status bitmaps done");
    wr_reg(mio_pkg::ADDR_TRIGFN, {8'h00, mio_pkg::FN_CNT_TRIG});
    wr_reg(mio_pkg::ADDR_TERM, 16'h0003);
    wr_reg(mio_pkg::ADDR_PRE, 16'h0002);
    wr_reg(mio_pkg::ADDR_FN0, {8'h00, mio_pkg::FN_TERM});
    wr_reg(mio_pkg::ADDR_FN0 + 5'h01, {8'h00, mio_pkg::FN_PRELIM});
    wr_reg(mio_pkg::ADDR_IRQMSK, 16'h0003);
    trig();
    rd_reg(mio_pkg::ADDR_CNT, 16'h0001, "count");
    trig();
    wait_pins("preliminary", 4'b1010);
    rd_reg(mio_pkg::ADDR_CNT, 16'h0002, "count");
    wr_reg(mio_pkg::ADDR_IRQSTS, 16'h0002);
    wait_pins("irq clear", 4'b0010);
    trig();
    wait_pins("terminal", 4'b1001);
    rd_reg(mio_pkg::ADDR_CNT, 16'h0000, "count");
    rd_reg(mio_pkg::ADDR_IRQSTS, 16'h0001, "irq status");
    trig();
    wait_pins("terminal end", 4'b1000);
    wr_reg(mio_pkg::ADDR_IRQSTS, 16'h0001);
    wr_reg(mio_pkg::ADDR_TRIGFN, 16'h0016);
    trig();
    rd_reg(mio_pkg::ADDR_CNT, 16'h0001, "count");
    wait_pins("irq off", 4'b0000);
    $display("test counter done");
    for (int k = 0; k < 3; k++)
    begin
      run_held <= rs[k][1];
      wr_reg(mio_pkg::ADDR_RESTART, {15'h0000, rs[k][2]});
      n0 = run_cnt;
      @(posedge clk);
      reset_key <= 1'b1;
      @(posedge clk);
      reset_key <= 1'b0;
      repeat (4) @(posedge clk);
      cmp16("run start", {15'h0000, rs[k][0]}, 16'(run_cnt - n0));
    end
    $display("test restart done");
    out_freq <= 16'h1388;
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(mio_pkg::ADDR_GAIN, k ? 16'h0037 : 16'h0001);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (20000) @(posedge clk);
      #1;
      ee = 64'd20000 * 64'd5000 * (k ? 55 : 1) / (64'd100 * CLK_HZ_TB);
      ok = edges <= ee + 1 && edges + 1 >= ee &&
           highs <= 10000 + 10000 / ee + 2 && highs + 10000 / ee + 2 >= 10000;
      cmp16("pulse rate and duty", 16'h0001, {15'h0000, ok});
    end
    $display("test pulse output done");
    summarize();
  end
endmodule

`default_nettype wire
